//--- verilog/osc_pkg.sv
// constants and carrier types for the optical module sideband control
package osc_pkg;

  localparam int MON_W    = 16;
  localparam int NUM_CH   = 5;
  localparam int NUM_KIND = 5;

  // monitor channel order
  localparam int CH_TEMP = 0;
  localparam int CH_VCC  = 1;
  localparam int CH_BIAS = 2;
  localparam int CH_TXP  = 3;
  localparam int CH_RXP  = 4;

  // factory store kinds
  localparam logic [2:0] KIND_HI_ALM  = 3'h0;
  localparam logic [2:0] KIND_LO_ALM  = 3'h1;
  localparam logic [2:0] KIND_HI_WARN = 3'h2;
  localparam logic [2:0] KIND_LO_WARN = 3'h3;
  localparam logic [2:0] KIND_OFFSET  = 3'h4;

  // values after reset of the factory store
  localparam logic [MON_W-1:0] RST_HI  = 16'hFFFF;
  localparam logic [MON_W-1:0] RST_LO  = 16'h0000;
  localparam logic [MON_W-1:0] RST_OFS = 16'h0000;

  // serial map byte offsets and bits per byte
  localparam logic [7:0] MAP_MON_BASE = 8'h00;
  localparam logic [7:0] MAP_STATUS   = 8'h0A;
  localparam logic [7:0] MAP_ALARM    = 8'h0B;
  localparam logic [7:0] MAP_WARN     = 8'h0C;
  localparam logic [3:0] BITS_BYTE    = 4'h8;

  typedef struct packed {
    logic tx_off;
    logic tx_fault;
    logic receive_signal_lost;
    logic rx_rate;
    logic tx_rate;
  } osc_status_t;

  typedef struct packed {
    logic             en;
    logic [2:0]       kind;
    logic [2:0]       ch;
    logic [MON_W-1:0] data;
  } osc_fac_wr_t;

  typedef enum logic [4:0] {
    TW_IDLE = 5'b00001,
    TW_RECV = 5'b00010,
    TW_ACK  = 5'b00100,
    TW_SEND = 5'b01000,
    TW_RACK = 5'b10000
  } osc_tw_state_t;

endpackage : osc_pkg

//--- verilog/osc_mon_seq.sv
// round-robin conversion sequencer holding the live monitor values
`timescale 1ns/1ps
module osc_mon_seq #(
  parameter int MON_W  = 16,
  parameter int NUM_CH = 5
) (
  // clock and reset
  input  wire logic                           sys_clk_i,
  input  wire logic                           rst_i,
  input  wire logic                           ce_i,
  // converter
  output logic                                adc_start_o,
  output logic [$clog2(NUM_CH)-1:0]           adc_chan_o,
  input  wire logic                           adc_done_i,
  input  wire logic [MON_W-1:0]               adc_data_i,
  // calibration and results
  input  wire logic [NUM_CH-1:0][MON_W-1:0]   offset_i,
  output logic [NUM_CH-1:0][MON_W-1:0]        mon_o,
  output logic                                mon_valid_o
);

  localparam int CW = $clog2(NUM_CH);
  localparam logic [CW-1:0] LAST = CW'(NUM_CH - 1);

  logic              busy;
  logic [NUM_CH-1:0] seen;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      busy        <= 1'b0;
      adc_start_o <= 1'b0;
      adc_chan_o  <= '0;
    end else if (ce_i) begin
      adc_start_o <= !busy;
      if (!busy) begin
        busy <= 1'b1;
      end else if (adc_done_i) begin
        busy       <= 1'b0;
        adc_chan_o <= (adc_chan_o == LAST) ? '0 : adc_chan_o + 1'b1;
      end
    end
  end

  // offset trims the raw code; wraps rather than saturates, kept small on purpose
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mon_o <= '0;
      seen  <= '0;
    end else if (ce_i && busy && adc_done_i) begin
      mon_o[adc_chan_o] <= adc_data_i + offset_i[adc_chan_o];
      seen[adc_chan_o]  <= 1'b1;
    end
  end

  assign mon_valid_o = &seen;

  a_start_pulse: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (adc_start_o && ce_i) |=> !adc_start_o)
    else $error("conversion start held longer than one cycle");

endmodule : osc_mon_seq

//--- verilog/osc_sideband.sv
// sideband pins, monitoring and two-wire slave of the optical module
`timescale 1ns/1ps
module osc_sideband #(
  parameter int               FAULT_IMPL = 1,
  parameter logic [6:0]       DEV_ADDR   = 7'h51,
  parameter logic [15:0]      LOS_ASSERT = 16'h0100,
  parameter logic [15:0]      LOS_CLEAR  = 16'h0140
) (
  // clock and reset
  input  wire logic                       sys_clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       ce_i,
  // transmit off request pin, level and whether the host drives it
  input  wire logic                       tx_off_req_i,
  input  wire logic                       tx_off_drv_i,
  // rate select pins
  input  wire logic                       receive_rate_select_i,
  input  wire logic                       receive_rate_drv_i,
  input  wire logic                       transmit_rate_select_i,
  input  wire logic                       transmit_rate_drv_i,
  // laser control
  output logic                            tx_enable_o,
  output logic                            rx_rate_sel_o,
  output logic                            tx_rate_sel_o,
  input  wire logic                       laser_trip_i,
  // open-drain flags
  output logic                            tx_fault_o,
  output logic                            tx_fault_oe_o,
  output logic                            receive_signal_lost_o,
  output logic                            receive_signal_lost_oe_o,
  output logic                            module_absent_flag_o,
  output logic                            module_absent_flag_oe_o,
  // converter
  output logic                            adc_start_o,
  output logic [2:0]                      adc_chan_o,
  input  wire logic                       adc_done_i,
  input  wire logic [osc_pkg::MON_W-1:0]  adc_data_i,
  // factory store
  input  wire osc_pkg::osc_fac_wr_t       fac_wr_i,
  input  wire logic                       fac_lock_i,
  output logic                            fac_locked_o,
  // two-wire bus
  input  wire logic                       scl_i,
  input  wire logic                       sda_i,
  output logic                            sda_o,
  output logic                            sda_oe_o,
  // monitor state
  output logic [osc_pkg::NUM_CH-1:0]      alarm_o,
  output logic [osc_pkg::NUM_CH-1:0]      warn_o
);

  localparam int MW = osc_pkg::MON_W;
  localparam int NC = osc_pkg::NUM_CH;

  // pin resolution: the pull-up and pull-downs live inside the module
  logic tx_off_eff;
  logic rx_rate_eff;
  logic tx_rate_eff;
  assign tx_off_eff  = !tx_off_drv_i || tx_off_req_i;
  assign rx_rate_eff = receive_rate_drv_i && receive_rate_select_i;
  assign tx_rate_eff = transmit_rate_drv_i && transmit_rate_select_i;

  // transmitter control
  logic tx_off_s1;
  logic tx_off_s2;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tx_off_s1   <= 1'b1;
      tx_off_s2   <= 1'b1;
      tx_enable_o <= 1'b0;
    end else if (ce_i) begin
      tx_off_s1   <= tx_off_eff;
      tx_off_s2   <= tx_off_s1;
      tx_enable_o <= !tx_off_s2;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rx_rate_sel_o <= 1'b0;
      tx_rate_sel_o <= 1'b0;
    end else if (ce_i) begin
      rx_rate_sel_o <= rx_rate_eff;
      tx_rate_sel_o <= tx_rate_eff;
    end
  end

  // factory store, packed so a lock can be checked as a whole
  logic [osc_pkg::NUM_KIND-1:0][NC-1:0][MW-1:0] thr;
  logic                                         locked;
  assign fac_locked_o = locked;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      locked <= 1'b0;
      for (int c = 0; c < NC; c++) begin
        thr[osc_pkg::KIND_HI_ALM][c]  <= osc_pkg::RST_HI;
        thr[osc_pkg::KIND_LO_ALM][c]  <= osc_pkg::RST_LO;
        thr[osc_pkg::KIND_HI_WARN][c] <= osc_pkg::RST_HI;
        thr[osc_pkg::KIND_LO_WARN][c] <= osc_pkg::RST_LO;
        thr[osc_pkg::KIND_OFFSET][c]  <= osc_pkg::RST_OFS;
      end
    end else if (ce_i) begin
      if (fac_lock_i) begin
        locked <= 1'b1;
      end
      // once locked the field cannot alter trims or limits
      if (fac_wr_i.en && !locked && !fac_lock_i && fac_wr_i.kind < 3'(osc_pkg::NUM_KIND)
          && fac_wr_i.ch < 3'(NC)) begin
        thr[fac_wr_i.kind][fac_wr_i.ch] <= fac_wr_i.data;
      end
    end
  end

  // live monitoring
  logic [NC-1:0][MW-1:0] mon;
  logic                  mon_valid;

  osc_mon_seq #(
    .MON_W (MW),
    .NUM_CH(NC)
  ) u_mon_seq (
    .sys_clk_i  (sys_clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .adc_start_o(adc_start_o),
    .adc_chan_o (adc_chan_o),
    .adc_done_i (adc_done_i),
    .adc_data_i (adc_data_i),
    .offset_i   (thr[osc_pkg::KIND_OFFSET]),
    .mon_o      (mon),
    .mon_valid_o(mon_valid)
  );

  genvar g;
  generate
    for (g = 0; g < NC; g++) begin : g_cmp
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          alarm_o[g] <= 1'b0;
          warn_o[g]  <= 1'b0;
        end else if (ce_i) begin
          alarm_o[g] <= mon_valid && (mon[g] > thr[osc_pkg::KIND_HI_ALM][g]
                                   || mon[g] < thr[osc_pkg::KIND_LO_ALM][g]);
          warn_o[g]  <= mon_valid && (mon[g] > thr[osc_pkg::KIND_HI_WARN][g]
                                   || mon[g] < thr[osc_pkg::KIND_LO_WARN][g]);
        end
      end
    end
  endgenerate

  // transmit fault: sticky until the host asks for the transmitter off
  logic tx_fault;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tx_fault <= 1'b0;
    end else if (ce_i) begin
      // new cause wins over the clear in the same cycle
      tx_fault <= (FAULT_IMPL != 0)
               && (laser_trip_i || alarm_o[osc_pkg::CH_BIAS]
                   || (tx_fault && !tx_off_s2));
    end
  end

  // signal lost with hysteresis, held high until every channel has a sample
  logic receive_signal_lost;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      receive_signal_lost <= 1'b1;
    end else if (ce_i) begin
      if (!mon_valid || mon[osc_pkg::CH_RXP] < LOS_ASSERT) begin
        receive_signal_lost <= 1'b1;
      end else if (mon[osc_pkg::CH_RXP] >= LOS_CLEAR) begin
        receive_signal_lost <= 1'b0;
      end
    end
  end

  // open-drain pins: a high fault or signal-lost flag releases the pin to the host pull-up; module absent is always driven low
  assign tx_fault_o               = 1'b0;
  assign tx_fault_oe_o            = !tx_fault;
  assign receive_signal_lost_o    = 1'b0;
  assign receive_signal_lost_oe_o = !receive_signal_lost;
  assign module_absent_flag_o     = 1'b0;
  assign module_absent_flag_oe_o  = 1'b1;

  osc_pkg::osc_status_t status;
  assign status = '{tx_off: tx_off_s2, tx_fault: tx_fault, receive_signal_lost: receive_signal_lost,
                    rx_rate: rx_rate_sel_o, tx_rate: tx_rate_sel_o};

  // two-wire slave; edges are found by comparing the live bus pins with their values one clock earlier
  logic                  scl_q;
  logic                  sda_q;
  logic                  scl_rise;
  logic                  scl_fall;
  logic                  bus_start;
  logic                  bus_stop;
  osc_pkg::osc_tw_state_t tw_state;
  logic [7:0]            shreg;
  logic [3:0]            bitcnt;
  logic                  first;
  logic                  rd_mode;
  logic                  ptr_set;
  logic                  nack;
  logic [7:0]            ptr;
  logic [7:0]            map_byte;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (ce_i) begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  assign scl_rise  = scl_i && !scl_q;
  assign scl_fall  = !scl_i && scl_q;
  assign bus_start = scl_i && scl_q && sda_q && !sda_i;
  assign bus_stop  = scl_i && scl_q && !sda_q && sda_i;

  always_comb begin
    map_byte = 8'h00;
    if (ptr < 8'(2 * NC)) begin
      map_byte = ptr[0] ? mon[ptr[7:1]][7:0] : mon[ptr[7:1]][15:8];
    end else if (ptr == osc_pkg::MAP_STATUS) begin
      map_byte = {3'h0, status};
    end else if (ptr == osc_pkg::MAP_ALARM) begin
      map_byte = 8'(alarm_o);
    end else if (ptr == osc_pkg::MAP_WARN) begin
      map_byte = 8'(warn_o);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tw_state <= osc_pkg::TW_IDLE;
      shreg    <= 8'h00;
      bitcnt   <= 4'h0;
      first    <= 1'b0;
      rd_mode  <= 1'b0;
      ptr_set  <= 1'b0;
      nack     <= 1'b0;
      ptr      <= osc_pkg::MAP_MON_BASE;
    end else if (ce_i) begin
      if (bus_start) begin
        tw_state <= osc_pkg::TW_RECV;
        bitcnt   <= 4'h0;
        first    <= 1'b1;
        ptr_set  <= 1'b0;
      end else if (bus_stop) begin
        tw_state <= osc_pkg::TW_IDLE;
      end else begin
        unique case (tw_state)
          osc_pkg::TW_IDLE: begin
          end
          osc_pkg::TW_RECV: begin
            if (scl_rise) begin
              shreg  <= {shreg[6:0], sda_i};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == osc_pkg::BITS_BYTE) begin
              if (first) begin
                rd_mode  <= shreg[0];
                tw_state <= (shreg[7:1] == DEV_ADDR) ? osc_pkg::TW_ACK : osc_pkg::TW_IDLE;
              end else begin
                // only the first data byte sets the pointer; later ones are acked and dropped
                if (!ptr_set) begin
                  ptr <= shreg;
                end
                ptr_set  <= 1'b1;
                tw_state <= osc_pkg::TW_ACK;
              end
            end
          end
          osc_pkg::TW_ACK: begin
            if (scl_fall) begin
              first  <= 1'b0;
              bitcnt <= 4'h0;
              if (rd_mode) begin
                shreg    <= map_byte;
                ptr      <= ptr + 8'h01;
                tw_state <= osc_pkg::TW_SEND;
              end else begin
                tw_state <= osc_pkg::TW_RECV;
              end
            end
          end
          osc_pkg::TW_SEND: begin
            if (scl_fall) begin
              if (bitcnt == osc_pkg::BITS_BYTE - 4'h1) begin
                tw_state <= osc_pkg::TW_RACK;
              end else begin
                shreg  <= {shreg[6:0], 1'b0};
                bitcnt <= bitcnt + 4'h1;
              end
            end
          end
          osc_pkg::TW_RACK: begin
            if (scl_rise) begin
              nack <= sda_i;
            end else if (scl_fall) begin
              if (nack) begin
                tw_state <= osc_pkg::TW_IDLE;
              end else begin
                shreg    <= map_byte;
                ptr      <= ptr + 8'h01;
                bitcnt   <= 4'h0;
                tw_state <= osc_pkg::TW_SEND;
              end
            end
          end
        endcase
      end
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_o = (tw_state == osc_pkg::TW_ACK)
                 || (tw_state == osc_pkg::TW_SEND && !shreg[7]);

  a_tx_off_follow: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ce_i && tx_off_eff) [*3] |=> !tx_enable_o)
    else $error("transmitter not off after off request");

  a_tx_on_follow: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ce_i && !tx_off_eff) [*3] |=> tx_enable_o)
    else $error("transmitter not on after request released");

  a_fault_raise: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ce_i && laser_trip_i && FAULT_IMPL != 0) |=> !tx_fault_oe_o)
    else $error("fault pin not released after laser trip");

  a_fault_absent: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (FAULT_IMPL != 0) || tx_fault_oe_o)
    else $error("fault pin released with fault detection absent");

  a_los_raise: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ce_i && mon_valid && mon[osc_pkg::CH_RXP] < LOS_ASSERT) |=> !receive_signal_lost_oe_o)
    else $error("signal lost not flagged at low receive power");

  a_rate_pulldown: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ce_i && !receive_rate_drv_i && !transmit_rate_drv_i) |=> !rx_rate_sel_o && !tx_rate_sel_o)
    else $error("undriven rate select read high");

  a_absent_ground: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    module_absent_flag_oe_o && !module_absent_flag_o)
    else $error("module absent line not held low");

  a_store_locked: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    locked |=> $stable(thr) && locked)
    else $error("factory store changed after lock");

  a_addr_ack: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (tw_state == osc_pkg::TW_ACK) |-> sda_oe_o && !sda_o)
    else $error("acknowledge bit not driven low");

endmodule : osc_sideband

//--- verification/osc_host_model.sv
// host board model: flag pull-ups and two-wire bus master
`timescale 1ns/1ps
module osc_host_model (
  // clock
  input  wire logic sys_clk_i,
  // module side of the open-drain lines
  input  wire logic fault_i,
  input  wire logic fault_oe_i,
  input  wire logic los_i,
  input  wire logic los_oe_i,
  input  wire logic absent_i,
  input  wire logic absent_oe_i,
  input  wire logic sda_i,
  input  wire logic sda_oe_i,
  // resolved wires as the host sees them
  output logic      fault_pin_o,
  output logic      los_pin_o,
  output logic      absent_pin_o,
  output logic      scl_o,
  output logic      sda_o
);
  logic       h_sda = 1'b1;
  logic       h_scl = 1'b1;
  logic [7:0] rdbuf [0:3];

  // released flags float up to the host rail
  assign fault_pin_o  = fault_oe_i ? fault_i : 1'b1;
  assign los_pin_o    = los_oe_i ? los_i : 1'b1;
  assign absent_pin_o = absent_oe_i ? absent_i : 1'b1;
  assign sda_o        = h_sda & (sda_oe_i ? sda_i : 1'b1);
  assign scl_o        = h_scl;

  // a third of a bit; four clocks per level, the module needs one
  task hw();
    repeat (4) @(posedge sys_clk_i);
    #1;
  endtask : hw

  task start();
    h_sda = 1'b1;
    hw();
    h_scl = 1'b1;
    hw();
    h_sda = 1'b0;
    hw();
    h_scl = 1'b0;
    hw();
  endtask : start

  task stop();
    h_sda = 1'b0;
    hw();
    h_scl = 1'b1;
    hw();
    h_sda = 1'b1;
    hw();
  endtask : stop

  // drive b, sample the wire while clock is high
  task bitx(input logic b, output logic r);
    h_sda = b;
    hw();
    h_scl = 1'b1;
    hw();
    r = sda_o;
    h_scl = 1'b0;
    hw();
  endtask : bitx

  task xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], q[i]);
    end
    bitx(last, ack);
  endtask : xfer

  task rd(input logic [6:0] a, input logic [7:0] ptr, input int n, output logic ack);
    logic [7:0] q;
    logic       k;
    start();
    xfer({a, 1'b0}, 1'b1, q, ack);
    if (ack === 1'b0) begin
      xfer(ptr, 1'b1, q, k);
      start();
      xfer({a, 1'b1}, 1'b1, q, k);
      for (int i = 0; i < n; i++) begin
        xfer(8'hFF, i == n - 1, rdbuf[i], k);
      end
    end
    stop();
  endtask : rd
endmodule : osc_host_model

//--- verification/osc_sideband_tb.sv
// self-checking bench for the optical module sideband control
`timescale 1ns/1ps
module osc_sideband_tb;
  localparam logic [15:0] LA = 16'h0100;
  localparam logic [15:0] LC = 16'h0140;
  localparam logic [6:0]  DA = 7'h51;

  logic                 sys_clk_i = 1'b0;
  logic                 rst_i = 1'b1;
  logic                 ce_i = 1'b1;
  logic                 tx_off_req_i = 1'b1;
  logic                 tx_off_drv_i = 1'b0;
  logic                 receive_rate_select_i = 1'b0;
  logic                 receive_rate_drv_i = 1'b0;
  logic                 transmit_rate_select_i = 1'b0;
  logic                 transmit_rate_drv_i = 1'b0;
  logic                 laser_trip_i = 1'b0;
  logic                 adc_done_i = 1'b0;
  logic [15:0]          adc_data_i = 16'h0000;
  osc_pkg::osc_fac_wr_t fac_wr_i = '0;
  logic                 fac_lock_i = 1'b0;
  logic                 tx_enable_o, rx_rate_sel_o, tx_rate_sel_o, tx_fault_o, tx_fault_oe_o;
  logic                 receive_signal_lost_o, receive_signal_lost_oe_o, module_absent_flag_o;
  logic                 module_absent_flag_oe_o, adc_start_o, fac_locked_o, sda_o, sda_oe_o;
  logic [2:0]           adc_chan_o;
  logic [4:0]           alarm_o, warn_o;
  wire                  scl_i, sda_i, fault_pin, los_pin, abs_pin;
  int                   mismatches = 0;
  int                   n_checks = 0;
  int                   since_rst = 0;
  int                   ch4_cnt = 0;
  int                   cch;
  logic [2:0]           hist = 3'h7;
  logic                 rr_exp = 1'b0;
  logic                 tr_exp = 1'b0;
  logic [15:0]          adc_val [0:4];
  logic [15:0]          lv [0:4];
  logic                 le [0:4];
  logic [15:0]          v, ofs;
  logic                 ack;

  osc_sideband #(.FAULT_IMPL(1), .DEV_ADDR(DA), .LOS_ASSERT(LA), .LOS_CLEAR(LC)) dut_u (
    .sys_clk_i, .rst_i, .ce_i, .tx_off_req_i, .tx_off_drv_i, .receive_rate_select_i,
    .receive_rate_drv_i, .transmit_rate_select_i, .transmit_rate_drv_i, .tx_enable_o,
    .rx_rate_sel_o, .tx_rate_sel_o, .laser_trip_i, .tx_fault_o, .tx_fault_oe_o,
    .receive_signal_lost_o, .receive_signal_lost_oe_o, .module_absent_flag_o,
    .module_absent_flag_oe_o, .adc_start_o, .adc_chan_o, .adc_done_i, .adc_data_i,
    .fac_wr_i, .fac_lock_i, .fac_locked_o, .scl_i, .sda_i, .sda_o, .sda_oe_o, .alarm_o, .warn_o
  );

  osc_host_model host_u (
    .sys_clk_i, .fault_i(tx_fault_o), .fault_oe_i(tx_fault_oe_o), .los_i(receive_signal_lost_o),
    .los_oe_i(receive_signal_lost_oe_o), .absent_i(module_absent_flag_o),
    .absent_oe_i(module_absent_flag_oe_o), .sda_i(sda_o), .sda_oe_i(sda_oe_o),
    .fault_pin_o(fault_pin), .los_pin_o(los_pin), .absent_pin_o(abs_pin), .scl_o(scl_i),
    .sda_o(sda_i)
  );

  always #4 sys_clk_i = ~sys_clk_i;

  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task finish_test();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  // converter answers a few cycles after each start
  always @(posedge sys_clk_i) begin
    if (adc_start_o === 1'b1) begin
      cch = int'(adc_chan_o);
      repeat (2) @(posedge sys_clk_i);
      #1;
      adc_data_i = adc_val[cch];
      adc_done_i = 1'b1;
      @(posedge sys_clk_i);
      #1;
      adc_done_i = 1'b0;
      adc_data_i = ~adc_data_i;
      if (cch == 4) ch4_cnt++;
    end
  end

  // reference: off request through two sync stages and a register, frozen with the enable
  always @(posedge sys_clk_i) begin
    if (ce_i) begin
      hist <= {hist[1:0], tx_off_req_i | ~tx_off_drv_i};
      rr_exp <= receive_rate_select_i & receive_rate_drv_i;
      tr_exp <= transmit_rate_select_i & transmit_rate_drv_i;
    end
    since_rst <= rst_i ? 0 : since_rst + 1;
  end

  always @(negedge sys_clk_i) begin
    if (since_rst > 3) begin
      chk({tx_enable_o, rx_rate_sel_o, tx_rate_sel_o},
          {~hist[2], rr_exp, tr_exp});
    end
  end

  // two full conversions of the receive channel, so fresh data has landed
  task rounds();
    int t;
    t = ch4_cnt + 2;
    for (int j = 0; j < 400 && ch4_cnt < t; j++) @(posedge sys_clk_i);
    repeat (3) @(posedge sys_clk_i);
    #1;
  endtask : rounds

  task fac(input logic [2:0] kd, input logic [2:0] c, input logic [15:0] d);
    fac_wr_i = '{en: 1'b1, kind: kd, ch: c, data: d};
    @(posedge sys_clk_i);
    #1;
    fac_wr_i = '0;
    @(posedge sys_clk_i);
    #1;
  endtask : fac

  initial begin
    repeat (60000) @(posedge sys_clk_i);
    mismatches++;
    finish_test();
  end

  initial begin
    int k;
    void'($urandom(32'h90b2));
    adc_val = '{16'h1000, 16'h1000, 16'h1000, 16'h1000, 16'h0080};
    lv = '{LC, LA, LA - 16'h0001, LC - 16'h0001, LC};
    le = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    repeat (20) @(posedge sys_clk_i);
    #1;
    rst_i = 1'b0;
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk({fault_pin, los_pin, abs_pin}, 3'b010);
    repeat (60) begin
      {tx_off_req_i, tx_off_drv_i, receive_rate_select_i, receive_rate_drv_i,
       transmit_rate_select_i, transmit_rate_drv_i} = 6'($urandom);
      @(posedge sys_clk_i);
      #1;
    end
    {tx_off_req_i, tx_off_drv_i} = 2'b01;
    {receive_rate_select_i, receive_rate_drv_i} = 2'b11;
    {transmit_rate_select_i, transmit_rate_drv_i} = 2'b01;
    repeat (4) @(posedge sys_clk_i);
    #1;
    laser_trip_i = 1'b1;
    @(posedge sys_clk_i);
    #1;
    laser_trip_i = 1'b0;
    chk(fault_pin, 1'b1);
    repeat (6) @(posedge sys_clk_i);
    #1;
    chk(fault_pin, 1'b1);
    tx_off_req_i = 1'b1;
    for (k = 0; k < 20 && fault_pin !== 1'b0; k++) @(posedge sys_clk_i);
    #1;
    chk(fault_pin, 1'b0);
    tx_off_req_i = 1'b0;
    // hysteresis walk across both thresholds
    for (int i = 0; i < 5; i++) begin
      adc_val[4] = lv[i];
      rounds();
      chk(los_pin, le[i]);
    end
    v = 16'($urandom);
    ofs = 16'($urandom);
    adc_val[0] = v;
    adc_val[1] = 16'h2000;
    fac(3'h4, 3'h0, ofs);
    fac(3'h0, 3'h1, 16'h1000);
    rounds();
    chk({alarm_o, warn_o}, {5'h02, 5'h00});
    host_u.rd(DA, 8'h00, 2, ack);
    chk({ack, host_u.rdbuf[0], host_u.rdbuf[1]}, {1'b0, v + ofs});
    host_u.rd(DA, 8'h0A, 3, ack);
    chk({host_u.rdbuf[0], host_u.rdbuf[1], host_u.rdbuf[2]}, 24'h020200);
    // store is frozen once locked
    fac_lock_i = 1'b1;
    @(posedge sys_clk_i);
    #1;
    fac_lock_i = 1'b0;
    fac(3'h4, 3'h0, ~ofs);
    rounds();
    host_u.rd(DA, 8'h00, 2, ack);
    chk({fac_locked_o, host_u.rdbuf[0], host_u.rdbuf[1]}, {1'b1, v + ofs});
    host_u.rd(DA ^ 7'h01, 8'h00, 1, ack);
    chk(ack, 1'b1);
    // enable low freezes the off path; runs last since a missed converter done stalls it
    ce_i = 1'b0;
    tx_off_req_i = 1'b1;
    repeat (5) @(posedge sys_clk_i);
    #1;
    chk(tx_enable_o, 1'b1);
    ce_i = 1'b1;
    repeat (4) @(posedge sys_clk_i);
    #1;
    chk(tx_enable_o, 1'b0);
    finish_test();
  end
endmodule : osc_sideband_tb
